// ==== logic/sar_defines.svh ====
// timing and width constants for the successive approximation register
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH
`define SAR_WIDTH     8
`define SAR_MSB       3'h7
`define SAR_ZERO      8'h00
`define SAR_MSB_ONLY  8'h80
// cycles a trial waits for the comparator to pass the input synchroniser
`define SAR_SETTLE    3'h4
`endif

// ==== logic/sar_pkg.sv ====
// types for the successive approximation register
package sar_pkg;
  typedef enum logic [1:0] {
    SAR_CLEARED,
    SAR_FIRST,
    SAR_TRIAL,
    SAR_DONE
  } sar_state_t;

  typedef struct packed {
    logic [7:0] trial_bits;
    logic       serial_result;
    logic       done;
  } sar_result_t;
endpackage

// ==== logic/sar_core.sv ====
// successive approximation register core with clear and shortening variants
//
// Function
// (RULE_01) all inputs are taken only at the rising clock edge; code takes arst_n asynchronously, at its falling edge
// (RULE_02) a low-to-high request seen at a rising edge starts a conversion
// (RULE_03) comparator input is synchronised and decides the current trial bit
// (RULE_04) clear variant: master clear zeroes all outputs at next rising edge; code zeroes them at fifth rising edge, done at the falling edge after
// (RULE_05) clear released with request low keeps device cleared until request high
// (RULE_06) each cycle the next trial bit is set high then conditionally cleared; code takes one step every five clock cycles
// (RULE_07) a resolved trial bit holds until clear or a new start
// (RULE_08) done rises on falling edge after lsb resolution or shortening tap high
// (RULE_09) serial result shows each bit while its parallel bit is resolved
// (RULE_10) serial output inactive in first period, when cleared, second cycle after done
// (RULE_11) with done low and clocking, no stable idle state exists
// (RULE_12) shortening variant restarts after done when request is high
// (RULE_13) free-running and strobed modes; done fed to request restarts at once
// (RULE_14) system ties output below lsb used to shortening tap, ignores lower bits
// (RULE_15) for full eight bits the system holds the shortening tap low
// (RULE_16) cascaded clear variant keeps serial inhibited until its second cycle
// (RULE_17) trial bits resolve from msb down to lsb, one per cycle; code resolves one bit per five clock cycles
`timescale 1ns/1ps
`include "sar_defines.svh"

module sar_core
  import sar_pkg::*;
#(
  parameter bit CLEAR_VARIANT = 1'b1
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       conversion_request,
  input  wire logic       comparator_in,
  input  wire logic       master_clear,
  input  wire logic       shortening_tap,
  output logic [7:0]      trial_bits,
  output logic            serial_result,
  output logic            done
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: three stages, change taken once stages two and three agree
  logic [2:0] sync_req;
  logic [2:0] sync_cmp;
  logic [2:0] sync_clr;
  logic [2:0] sync_tap;
  logic       req_q;
  logic       cmp_q;
  logic       clr_q;
  logic       tap_q;
  logic       next_req_q;
  logic       next_cmp_q;
  logic       next_clr_q;
  logic       next_tap_q;

  always_comb begin
    next_req_q = (sync_req[1] == sync_req[2]) ? sync_req[2] : req_q;
    next_cmp_q = (sync_cmp[1] == sync_cmp[2]) ? sync_cmp[2] : cmp_q;
    next_clr_q = (sync_clr[1] == sync_clr[2]) ? sync_clr[2] : clr_q;
    next_tap_q = (sync_tap[1] == sync_tap[2]) ? sync_tap[2] : tap_q;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin // RULE_01
    if (!arst_n) begin
      sync_req <= 3'h0;
      sync_cmp <= 3'h0;
      sync_clr <= 3'h0;
      sync_tap <= 3'h0;
      req_q    <= 1'b0;
      cmp_q    <= 1'b0;
      clr_q    <= 1'b0;
      tap_q    <= 1'b0;
    end else begin
      sync_req <= {sync_req[1:0], conversion_request};
      sync_cmp <= {sync_cmp[1:0], comparator_in}; // RULE_03
      sync_clr <= {sync_clr[1:0], master_clear};
      sync_tap <= {sync_tap[1:0], shortening_tap};
      req_q    <= next_req_q;
      cmp_q    <= next_cmp_q;
      clr_q    <= next_clr_q;
      tap_q    <= next_tap_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion state machine
  sar_state_t state;
  sar_state_t next_state;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [7:0] next_trial_bits;
  logic       next_serial_result;
  logic       req_prev;
  logic       done_pend;
  logic       next_done_pend;
  logic       post_done;
  logic       next_post_done;
  logic       serial_inhibit;
  logic       next_serial_inhibit;
  logic       clear_now;
  logic       start_now;
  logic       tap_end;
  logic [2:0] step_cnt;
  logic [2:0] next_step_cnt;
  logic       step_en;

  // one-cycle step pulse: a trial bit is decided only once the comparator
  // answer to it has crossed the synchroniser
  assign step_en   = (step_cnt == `SAR_SETTLE);
  assign clear_now = CLEAR_VARIANT && clr_q;
  assign tap_end   = !CLEAR_VARIANT && tap_q;
  // rising request, a level request after done or while cleared (restart and free run), or shortening variant in cleared state
  assign start_now = (req_q && !req_prev) // RULE_02
                   || (req_q && state == SAR_DONE) // RULE_12 RULE_13
                   || (req_q && state == SAR_CLEARED) // RULE_05 RULE_11
                   || (!CLEAR_VARIANT && state == SAR_CLEARED); // RULE_11

  always_comb begin
    next_state          = state;
    next_bit_idx        = bit_idx;
    next_step_cnt       = step_cnt;
    next_trial_bits     = trial_bits;
    next_serial_result  = 1'b0;
    next_done_pend      = 1'b0;
    next_post_done      = 1'b0;
    next_serial_inhibit = serial_inhibit;
    if (clear_now) begin
      next_state          = SAR_CLEARED; // RULE_04
      next_trial_bits     = `SAR_ZERO;
      next_bit_idx        = `SAR_MSB;
      next_step_cnt       = 3'h0;
      next_serial_inhibit = 1'b1;
    end else if (start_now) begin
      // first period: msb set high, serial held low
      next_state      = SAR_FIRST;
      next_trial_bits = `SAR_MSB_ONLY; // RULE_06
      next_bit_idx    = `SAR_MSB; // RULE_17
      next_step_cnt   = 3'h0;
      next_post_done  = 1'b0; // RULE_10
      next_serial_inhibit = CLEAR_VARIANT; // RULE_16
    end else begin
      case (state)
        SAR_CLEARED: begin
          // leaves on a request level, or at once in the shortening variant; held by RULE_05
          next_state = SAR_CLEARED; // RULE_05
        end
        SAR_FIRST, SAR_TRIAL: begin
          if (!step_en) begin
            next_step_cnt = step_cnt + 3'h1;
          end else begin
            next_step_cnt            = 3'h0;
            next_trial_bits[bit_idx] = cmp_q; // RULE_03 RULE_06
            next_serial_result       = cmp_q && !(state == SAR_FIRST && serial_inhibit); // RULE_09
            next_serial_inhibit      = 1'b0;
            if (bit_idx == 3'h0 || tap_end) begin
              next_state     = SAR_DONE;
              next_done_pend = 1'b1; // RULE_08
            end else begin
              next_state                      = SAR_TRIAL; // RULE_11
              next_bit_idx                    = bit_idx - 3'h1; // RULE_17
              next_trial_bits[bit_idx - 3'h1] = 1'b1; // RULE_06
            end
          end
        end
        SAR_DONE: begin
          next_post_done = 1'b1;
          next_state     = SAR_DONE; // RULE_07
        end
        default: begin
          next_state = SAR_CLEARED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state          <= SAR_CLEARED;
      bit_idx        <= `SAR_MSB;
      step_cnt       <= 3'h0;
      trial_bits     <= `SAR_ZERO;
      serial_result  <= 1'b0;
      req_prev       <= 1'b0;
      done_pend      <= 1'b0;
      post_done      <= 1'b0;
      serial_inhibit <= 1'b1;
    end else begin
      state          <= next_state;
      bit_idx        <= next_bit_idx;
      step_cnt       <= next_step_cnt;
      trial_bits     <= next_trial_bits; // RULE_07
      serial_result  <= next_serial_result && !post_done; // RULE_10
      req_prev       <= req_q;
      done_pend      <= next_done_pend || (state == SAR_DONE && !start_now && !clear_now);
      post_done      <= next_post_done;
      serial_inhibit <= next_serial_inhibit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flag changes on the falling edge, giving the parallel bits half a cycle
  always_ff @(negedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
    end else begin
      done <= done_pend && state == SAR_DONE; // RULE_08
    end
  end

endmodule // sar_core

// ==== tb/sar_core_sva.sv ====
// port assertions for the successive approximation register
`timescale 1ns/1ps
module sar_core_sva #(parameter bit CLEAR_VARIANT = 1'b1) (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       conversion_request,
  input wire logic       master_clear,
  input wire logic [7:0] trial_bits,
  input wire logic       serial_result,
  input wire logic       done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire clr = CLEAR_VARIANT && master_clear;
  wire run = conversion_request && !clr;
  sequence s_go; $rose(conversion_request) && !clr; endsequence
  sequence s_first; trial_bits == 8'h80 && !done && !clr; endsequence
  property p_start; s_go |-> ##[1:8] trial_bits == 8'h80; endproperty
  property p_order; s_first |-> ##[1:8] trial_bits[6]; endproperty
  property p_clear; clr[*6] |-> trial_bits == 8'h00 && !serial_result && !done; endproperty
  property p_stay;
    CLEAR_VARIANT && $fell(master_clear) ##1 (!conversion_request)[*8] |-> trial_bits == 8'h00;
  endproperty
  property p_hold;
    $rose(done) && !conversion_request |=> ($stable(trial_bits[7:2]))[*3];
  endproperty
  property p_live; run && !done |-> ##[1:60] (done || !run); endproperty
  property p_again; done && run |-> ##[1:8] !done; endproperty
  property p_lsb; CLEAR_VARIANT && $rose(trial_bits[0]) |-> ##[1:8] done; endproperty
  a_start: assert property (p_start) else $error("no start");
  a_order: assert property (p_order) else $error("bad order");
  a_clear: assert property (p_clear) else $error("not cleared");
  a_stay: assert property (p_stay) else $error("left clear");
  a_hold: assert property (p_hold) else $error("result moved");
  a_live: assert property (p_live) else $error("stuck idle");
  a_again: assert property (p_again) else $error("no restart");
  a_lsb: assert property (p_lsb) else $error("late done");
endmodule // sar_core_sva
bind sar_core sar_core_sva #(.CLEAR_VARIANT(CLEAR_VARIANT)) sar_core_sva_inst (
  .clk_sys(clk_sys), .arst_n(arst_n), .conversion_request(conversion_request),
  .master_clear(master_clear), .trial_bits(trial_bits), .serial_result(serial_result),
  .done(done));

// ==== tb/sar_adc_model.sv ====
// comparator and converter facing the register
`timescale 1ns/1ps
module sar_adc_model (
  input  wire logic [7:0] trial_bits,
  input  wire logic [7:0] target,
  input  wire logic       tap_en,
  output logic            comparator_in,
  output logic            shortening_tap
);
  assign comparator_in = trial_bits <= target;
  assign shortening_tap = tap_en & trial_bits[1];
endmodule // sar_adc_model

// ==== tb/test_sar_core.sv ====
// self-checking bench for the successive approximation register
`timescale 1ns/1ps
module test_sar_core;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic conversion_request = 1'b0;
  logic master_clear = 1'b0;
  logic tap_en = 1'b0;
  logic [7:0] target = 8'h00;
  logic [7:0] tv [4] = '{8'hFF, 8'h00, 8'hA5, 8'h5A};
  wire [7:0] q [2];
  wire so [2];
  wire dn [2];
  int failures = 0;
  int check_count = 0;
  int ones [2] = '{0, 0};
  initial forever #4 clk_sys = ~clk_sys;
  // serial ones are counted where the outputs are settled
  always @(negedge clk_sys) for (int v = 0; v < 2; v++) if (so[v] === 1'b1) ones[v]++;
  for (genvar v = 0; v < 2; v++) begin : g
    wire cmp, tap;
    sar_adc_model sar_adc_model_inst (.trial_bits(q[v]), .target(target), .tap_en(tap_en),
      .comparator_in(cmp), .shortening_tap(tap));
    sar_core #(.CLEAR_VARIANT(1'(v))) sar_core_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .conversion_request(conversion_request), .comparator_in(cmp), .master_clear(master_clear),
      .shortening_tap(tap), .trial_bits(q[v]), .serial_result(so[v]), .done(dn[v]));
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_done(input int v, input logic lvl);
    for (int i = 0; i < 80 && dn[v] !== lvl; i++) @(posedge clk_sys);
    check({7'h00, dn[v]}, {7'h00, lvl});
  endtask
  task automatic start(input logic [7:0] tgt);
    target <= tgt;
    conversion_request <= 1'b1;
    tick(6);
    conversion_request <= 1'b0;
    ones = '{0, 0};
  endtask
  initial begin
    tick(3);
    arst_n <= 1'b1;
    tick(2);
    foreach (tv[i]) begin
      start(tv[i]);
      wait_done(0, 1'b1);
      wait_done(1, 1'b1);
      tick(4);
      check(q[0], tv[i]);
      check(q[1], tv[i]);
      check(8'(ones[0]), 8'($countones(tv[i])));
      check(8'(ones[1]), 8'($countones(tv[i][6:0])));
    end
    start(8'hFF);
    master_clear <= 1'b1;
    tick(8);
    check(q[1], 8'h00);
    check({6'h00, so[1], dn[1]}, 8'h00);
    master_clear <= 1'b0;
    tick(20);
    check(q[1], 8'h00);
    conversion_request <= 1'b1;
    for (int v = 0; v < 2; v++) begin
      wait_done(v, 1'b0);
      wait_done(v, 1'b1);
      wait_done(v, 1'b0);
      wait_done(v, 1'b1);
    end
    conversion_request <= 1'b0;
    tick(30);
    tap_en <= 1'b1;
    start(8'hFF);
    wait_done(0, 1'b1);
    check({2'h0, q[0][7:2]}, 8'h3F);
    report_and_stop();
  end
  initial begin
    #20us;
    failures++;
    report_and_stop();
  end
endmodule // test_sar_core
